/* File: host_irq_pkg.sv */
// Constants, field layouts and types for the host IRQ line controller.
package host_irq_pkg;

	// APB address width and register byte addresses.
	localparam int ADDR_W = 18;
	localparam logic [15:0] CTRL_IDX = 16'hFEA2;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] HIF_ADDR = 18'h3FA80;
	localparam logic [ADDR_W-1:0] STAT_ADDR = 18'h3FA90;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 18'h3FA94;

	// Reset values.
	localparam logic [7:0] CTRL_RESET = 8'h07;
	localparam logic [7:0] HIF_RESET = 8'h00;

	// Line indices, equal to the firmware bit positions.
	localparam int NUM_LINES = 3;
	localparam int LINE_KBD = 0;
	localparam int LINE_MOUSE = 1;
	localparam int LINE_PM = 2;

	// Field positions in host_if_control.
	localparam int HIF_KBD_EN = 0;
	localparam int HIF_MOUSE_EN = 1;
	localparam int HIF_PM_EN = 4;
	localparam int HIF_PM_COMPAT = 7;

	// Shape mode codes and pulse widths in core clock cycles.
	localparam logic [2:0] MODE_LEVEL = 3'h0;
	localparam logic [2:0] MODE_P1 = 3'h1;
	localparam logic [2:0] MODE_P2 = 3'h2;
	localparam logic [2:0] MODE_P4 = 3'h3;
	localparam logic [2:0] MODE_P8 = 3'h4;
	localparam logic [2:0] MODE_P16 = 3'h5;
	localparam logic [4:0] WIDTH_1 = 5'h01;
	localparam logic [4:0] WIDTH_2 = 5'h02;
	localparam logic [4:0] WIDTH_4 = 5'h04;
	localparam logic [4:0] WIDTH_8 = 5'h08;
	localparam logic [4:0] WIDTH_16 = 5'h10;
	localparam logic [4:0] WIDTH_NONE = 5'h00;

	// Layout of host_irq_control.
	typedef struct packed {
		logic rsvd;
		logic irq_invert;
		logic [2:0] irq_shape_mode;
		logic [2:0] fw_bits;
	} irq_ctrl_s;

	// APB request signals from the master.
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage : host_irq_pkg

/* File: host_irq_line_control.sv */
// Host IRQ line controller with APB register access and a core interrupt.
`timescale 1ns/1ps
// Functional notes
// - Reset loads host_irq_control with 07 hex, firmware bits set.
// - Keyboard hardware enable clear: IRQ1 follows firmware bit 0.
// - Reading firmware bit 0 returns the live IRQ1 level.
// - Mouse hardware enable clear: IRQ12 follows firmware bit 1.
// - Reading firmware bit 1 returns the live IRQ12 level.
// - PM legacy mode, enable clear: IRQ11 follows firmware bit 2.
// - Reading firmware bit 2 returns the live IRQ11 level.
// - Mode field bits 5 to 3 pick level or pulse and width.
// - Level mode, no invert: line high while buffer-full flag set.
// - Pulse mode, no invert: idle high, low pulse on buffer write.
// - Codes 1 to 5 give 1, 2, 4, 8, 16 cycles; others reserved.
// - Invert bit 6 flips hardware-driven lines.
// - Keyboard enabled: write to keyboard out data fires IRQ1.
module host_irq_line_control
	import host_irq_pkg::*;
#(
	parameter int CNT_W = 5
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// APB slave.
	input wire apb_req_s apb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Output buffer write strobes and full flags, same clock.
	input wire logic [NUM_LINES-1:0] obuf_wr_i,
	input wire logic [NUM_LINES-1:0] obf_i,
	// Host interrupt lines: bit 0 IRQ1, bit 1 IRQ12, bit 2 IRQ11.
	output logic [NUM_LINES-1:0] host_irq_o,
	// Core interrupt.
	output logic core_irq_o
);

	// The counter must hold the widest pulse.
	if (CNT_W < 5) begin : g_bad_cnt
		$error("CNT_W must be at least 5");
	end

	// Maps a shape mode code to its pulse width; zero means no pulse.
	function automatic logic [CNT_W-1:0] pulse_len(input logic [2:0] m);
		logic [4:0] w;
		w = WIDTH_NONE;
		case (m)
			MODE_P1: w = WIDTH_1;
			MODE_P2: w = WIDTH_2;
			MODE_P4: w = WIDTH_4;
			MODE_P8: w = WIDTH_8;
			MODE_P16: w = WIDTH_16;
			default: w = WIDTH_NONE;
		endcase
		// Reserved codes map to zero so they never start a pulse.
		return CNT_W'(w);
	endfunction : pulse_len

	// Address decode shared by read and write paths.
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a == CTRL_ADDR) || (a == HIF_ADDR) ||
			(a == STAT_ADDR) || (a == MASK_ADDR);
	endfunction : mapped

	irq_ctrl_s ctrl, next_ctrl;
	logic [7:0] hif, next_hif;
	logic [NUM_LINES-1:0] stat, next_stat;
	logic [NUM_LINES-1:0] mask, next_mask;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_core_irq;
	logic [NUM_LINES-1:0] hw_en, fw_en, trig;
	logic [NUM_LINES-1:0] next_line;
	logic [CNT_W-1:0] cnt [NUM_LINES];
	logic [CNT_W-1:0] next_cnt [NUM_LINES];
	logic [CNT_W-1:0] width;
	logic rd_fire, wr_fire;

	// Per-line ownership and hardware triggers.
	always_comb begin
		hw_en[LINE_KBD] = hif[HIF_KBD_EN];
		hw_en[LINE_MOUSE] = hif[HIF_MOUSE_EN];
		// IRQ11 has no owner, and is held low, outside legacy mode.
		hw_en[LINE_PM] = hif[HIF_PM_EN] & hif[HIF_PM_COMPAT];
		fw_en[LINE_KBD] = ~hif[HIF_KBD_EN];
		fw_en[LINE_MOUSE] = ~hif[HIF_MOUSE_EN];
		fw_en[LINE_PM] = ~hif[HIF_PM_EN] & hif[HIF_PM_COMPAT];
		trig = obuf_wr_i & hw_en;
		width = pulse_len(ctrl.irq_shape_mode);
	end

	// Reads are decoded in the first access cycle and answered with pready in the next, writes land with pready.
	always_comb begin
		rd_fire = apb_i.psel & apb_i.penable & ~pready_o;
		wr_fire = apb_i.psel & apb_i.penable & pready_o & apb_i.pwrite &
			mapped(apb_i.paddr);
		next_pready = rd_fire;
		next_pslverr = rd_fire & ~mapped(apb_i.paddr);
		next_prdata = 32'h0;
		if (rd_fire && !apb_i.pwrite) begin
			case (apb_i.paddr)
				// Low bits show the driven lines, as the host sees them.
				CTRL_ADDR: next_prdata = {24'h0, ctrl[7:3],
					host_irq_o};
				HIF_ADDR: next_prdata = {24'h0, hif};
				STAT_ADDR: next_prdata = {29'h0, stat};
				MASK_ADDR: next_prdata = {29'h0, mask};
				default: next_prdata = 32'h0;
			endcase
		end
	end

	// Register writes, sticky status with set winning over clear.
	always_comb begin
		next_ctrl = ctrl;
		next_hif = hif;
		next_mask = mask;
		next_stat = stat;
		// Bit 7 of the control register is reserved and kept at zero.
		if (wr_fire) begin
			case (apb_i.paddr)
				CTRL_ADDR: next_ctrl = {1'b0, apb_i.pwdata[6:0]};
				HIF_ADDR: next_hif = apb_i.pwdata[7:0];
				STAT_ADDR: next_stat = stat & ~apb_i.pwdata[2:0];
				MASK_ADDR: next_mask = apb_i.pwdata[2:0];
				default: next_ctrl = ctrl;
			endcase
		end
		// Triggers are merged last so an event wins over a clear.
		next_stat = next_stat | trig;
		next_core_irq = |(next_stat & next_mask);
	end

	// Register state and bus outputs.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl <= CTRL_RESET;
			hif <= HIF_RESET;
			stat <= '0;
			mask <= '0;
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			core_irq_o <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			hif <= next_hif;
			stat <= next_stat;
			mask <= next_mask;
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
			core_irq_o <= next_core_irq;
		end
	end

	// One pulse counter and line driver per host interrupt line.
	for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
		logic raw;

		// Counter and line level.
		always_comb begin
			raw = 1'b0;
			next_cnt[i] = cnt[i];
			// A strobe reloads the full width, even mid-pulse.
			if (trig[i] && width != '0) begin
				next_cnt[i] = width;
			end else if (cnt[i] != '0) begin
				next_cnt[i] = cnt[i] - CNT_W'(1);
			end
			if (ctrl.irq_shape_mode == MODE_LEVEL) begin
				raw = obf_i[i];
			end else begin
				raw = (next_cnt[i] == '0);
			end
			// Invert shapes hardware lines only; firmware bits pass as is.
			if (hw_en[i]) begin
				next_line[i] = raw ^ ctrl.irq_invert;
			end else if (fw_en[i]) begin
				next_line[i] = ctrl.fw_bits[i];
			end else begin
				next_line[i] = 1'b0;
			end
		end

		// Registered counter and output.
		always_ff @(posedge ref_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				cnt[i] <= '0;
				host_irq_o[i] <= 1'b0;
			end else begin
				cnt[i] <= next_cnt[i];
				host_irq_o[i] <= next_line[i];
			end
		end
	end

	// Checks run on the core clock and, except the reset value check, rest while reset is low.
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Checks.
	a_reset_ctrl_value: assert property (
		@(posedge ref_clk_i) disable iff (1'b0)
		$rose(rstn_i) |-> ctrl == CTRL_RESET)
		else $error("control register not at reset value");

	a_kbd_fw_drive: assert property (
		!hif[HIF_KBD_EN] |=> host_irq_o[LINE_KBD] == $past(ctrl.fw_bits[0]))
		else $error("IRQ1 not following firmware bit");

	a_mouse_fw_drive: assert property (
		!hif[HIF_MOUSE_EN] |=>
		host_irq_o[LINE_MOUSE] == $past(ctrl.fw_bits[1]))
		else $error("IRQ12 not following firmware bit");

	a_pm_fw_drive: assert property (
		hif[HIF_PM_COMPAT] && !hif[HIF_PM_EN] |=>
		host_irq_o[LINE_PM] == $past(ctrl.fw_bits[2]))
		else $error("IRQ11 not following firmware bit");

	a_line_readback: assert property (
		rd_fire && !apb_i.pwrite && apb_i.paddr == CTRL_ADDR |=>
		prdata_o[2:0] == $past(host_irq_o) && pready_o)
		else $error("control read does not return line levels");

	a_level_follow: assert property (
		hw_en[LINE_KBD] && ctrl.irq_shape_mode == MODE_LEVEL &&
		!ctrl.irq_invert |=> host_irq_o[LINE_KBD] == $past(obf_i[LINE_KBD]))
		else $error("level mode IRQ1 does not track buffer-full flag");

	a_level_invert: assert property (
		hw_en[LINE_MOUSE] && ctrl.irq_shape_mode == MODE_LEVEL &&
		ctrl.irq_invert |=>
		host_irq_o[LINE_MOUSE] == !$past(obf_i[LINE_MOUSE]))
		else $error("inverted level IRQ12 wrong");

	sequence s_pulse4_start;
		trig[LINE_KBD] && ctrl.irq_shape_mode == MODE_P4 &&
		!ctrl.irq_invert;
	endsequence

	sequence s_quiet_cfg;
		!trig[LINE_KBD] && $stable(ctrl) && $stable(hif);
	endsequence

	a_pulse_width: assert property (
		s_pulse4_start ##1 s_quiet_cfg [*5] |->
		host_irq_o[LINE_KBD] && $past(host_irq_o[LINE_KBD]) == 1'b0 &&
		$past(host_irq_o[LINE_KBD], 4) == 1'b0)
		else $error("four-cycle IRQ1 pulse has wrong width");

	a_pulse_restart: assert property (
		cnt[LINE_KBD] != '0 && trig[LINE_KBD] && width != '0 |=>
		cnt[LINE_KBD] == $past(width))
		else $error("pulse not restarted by new write");

	a_status_set_wins: assert property (
		trig[LINE_PM] |=> stat[LINE_PM] ##1 core_irq_o == |(stat & mask))
		else $error("status event lost or core irq wrong");

	// A bus answer lasts one cycle, so no access sees a stale ready.
	a_ready_one_cycle: assert property (
		pready_o |=> !pready_o)
		else $error("pready held longer than one cycle");

	// An error response always comes with the ready pulse.
	a_slverr_with_ready: assert property (
		pslverr_o |-> pready_o)
		else $error("pslverr without pready");

	// A write of ones clears status bits unless an event hits them too.
	a_status_w1c: assert property (
		wr_fire && apb_i.paddr == STAT_ADDR |=>
		stat == (($past(stat) & ~$past(apb_i.pwdata[2:0])) |
		$past(trig)))
		else $error("status write one to clear wrong");

	// IRQ11 stays low while the PM channel is not in legacy mode.
	a_pm_off_low: assert property (
		!hif[HIF_PM_COMPAT] |=> !host_irq_o[LINE_PM])
		else $error("IRQ11 driven outside legacy mode");

	// A strobe starts the pulse on the next cycle, inverted if asked.
	a_kbd_pulse_start: assert property (
		trig[LINE_KBD] && width != '0 |=>
		host_irq_o[LINE_KBD] == $past(ctrl.irq_invert))
		else $error("IRQ1 pulse did not start after the write");

	// Reserved codes give no pulse, so an idle line stays high.
	a_reserved_idle: assert property (
		hw_en[LINE_KBD] && !ctrl.irq_invert &&
		ctrl.irq_shape_mode > MODE_P16 && cnt[LINE_KBD] == '0 |=>
		host_irq_o[LINE_KBD])
		else $error("IRQ1 pulsed under a reserved mode code");

	// A pulse-mode line with no pulse running rests high.
	a_pulse_idle_high: assert property (
		hw_en[LINE_PM] && ctrl.irq_shape_mode != MODE_LEVEL &&
		!ctrl.irq_invert && cnt[LINE_PM] == '0 && !trig[LINE_PM] |=>
		host_irq_o[LINE_PM])
		else $error("IRQ11 not idle high in pulse mode");

endmodule : host_irq_line_control

/* File: host_pic_model.sv */
// Host interrupt controller model that counts falling edges on IRQ1.
`timescale 1ns/1ps
module host_pic_model (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Host line IRQ1 and the count of pulses latched from it.
	input wire logic irq_i,
	output logic [7:0] edge_cnt_o
);
	logic prev;
	// Latches each falling edge, as an edge-triggered host input would.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev <= 1'b0;
			edge_cnt_o <= 8'h00;
		end else begin
			prev <= irq_i;
			if (prev && !irq_i) edge_cnt_o <= edge_cnt_o + 8'h01;
		end
	end
endmodule : host_pic_model

/* File: host_irq_line_control_tb_top.sv */
// Self-checking testbench for the host IRQ line controller.
`timescale 1ns/1ps
module host_irq_line_control_tb_top;
	import host_irq_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	apb_req_s apb = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic core_irq;
	logic [2:0] obuf_wr = 3'h0;
	logic [2:0] out_buffer_full_flag = 3'h0;
	logic [2:0] host_irq;
	logic [7:0] edges;
	logic [31:0] rd;
	logic err;
	int error_cnt = 0;
	int checks = 0;
	int w;
	// The 200 MHz core clock.
	always #2.5 ref_clk_i = ~ref_clk_i;
	host_irq_line_control u_host_irq_line_control (.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i), .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .obuf_wr_i(obuf_wr), .obf_i(out_buffer_full_flag),
		.host_irq_o(host_irq), .core_irq_o(core_irq));
	host_pic_model u_host_pic_model (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.irq_i(host_irq[0]), .edge_cnt_o(edges));
	// Compares one value and reports a mismatch.
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer, waiting for pready, then three idle edges.
	task xfer(input logic wr, input logic [17:0] a, input logic [31:0] d);
		apb.paddr <= a;
		apb.pwrite <= wr;
		apb.pwdata <= d;
		apb.psel <= 1'b1;
		@(posedge ref_clk_i);
		apb.penable <= 1'b1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask : xfer
	// Strobes a buffer write, optionally again mid-pulse, counts low cycles.
	task pulse(input int ln, input bit again, output int cnt);
		obuf_wr[ln] <= 1'b1;
		@(posedge ref_clk_i);
		obuf_wr[ln] <= 1'b0;
		cnt = 0;
		for (int k = 0; k < 40; k++) begin
			@(posedge ref_clk_i);
			if (k == 1 && again) obuf_wr[ln] <= 1'b1;
			if (k == 2) obuf_wr[ln] <= 1'b0;
			if (host_irq[ln] === 1'b0) cnt++;
		end
	endtask : pulse
	// Reset values and firmware-driven lines with live readback.
	task t_fw;
		xfer(1'b0, CTRL_ADDR, 32'h0);
		chk("ctrl reset", rd, 32'h03);
		chk("lines reset", host_irq, 3'h3);
		xfer(1'b1, HIF_ADDR, 32'h80);
		chk("pm fw reset", host_irq, 3'h7);
		xfer(1'b1, CTRL_ADDR, 32'h85);
		chk("fw lines", host_irq, 3'h5);
		xfer(1'b0, CTRL_ADDR, 32'h0);
		chk("fw read", rd, 32'h05);
		$display("test fw done");
	endtask : t_fw
	// Level mode follows the full flags, then the invert bit.
	task t_level;
		xfer(1'b1, HIF_ADDR, 32'h93);
		xfer(1'b1, CTRL_ADDR, 32'h00);
		out_buffer_full_flag <= 3'h5;
		repeat (3) @(posedge ref_clk_i);
		chk("level", host_irq, 3'h5);
		xfer(1'b0, CTRL_ADDR, 32'h0);
		chk("level read", rd, 32'h05);
		xfer(1'b1, CTRL_ADDR, 32'h40);
		chk("inverted", host_irq, 3'h2);
		out_buffer_full_flag <= 3'h0;
		$display("test level done");
	endtask : t_level
	// Mode codes 1 to 7, then a restart in the middle of a pulse.
	task t_pulse;
		logic [7:0] e0;
		for (int m = 1; m < 8; m++) begin
			xfer(1'b1, CTRL_ADDR, 32'(m << 3));
			e0 = edges;
			pulse(0, 1'b0, w);
			chk("width", w, (m < 6) ? (1 << (m - 1)) : 0);
			chk("host edges", edges - e0, (m < 6) ? 1 : 0);
		end
		xfer(1'b1, CTRL_ADDR, 32'h18);
		pulse(0, 1'b1, w);
		chk("restart", w, 7);
		$display("test pulse done");
	endtask : t_pulse
	// Core interrupt masking and clearing, then an unmapped address.
	task t_irq;
		chk("masked", core_irq, 1'b0);
		xfer(1'b1, MASK_ADDR, 32'h1);
		chk("core irq", core_irq, 1'b1);
		pulse(2, 1'b0, w);
		chk("pm width", w, 4);
		xfer(1'b0, STAT_ADDR, 32'h0);
		chk("status", rd, 32'h5);
		fork
			xfer(1'b1, STAT_ADDR, 32'h1);
			begin
				repeat (2) @(posedge ref_clk_i);
				obuf_wr[0] <= 1'b1;
				@(posedge ref_clk_i);
				obuf_wr[0] <= 1'b0;
			end
		join
		xfer(1'b0, STAT_ADDR, 32'h0);
		chk("set wins", rd, 32'h5);
		xfer(1'b1, STAT_ADDR, 32'h1);
		chk("cleared", core_irq, 1'b0);
		xfer(1'b0, STAT_ADDR, 32'h0);
		chk("w1c", rd, 32'h4);
		xfer(1'b0, 18'h3FA84, 32'h0);
		chk("slverr", err, 1'b1);
		chk("unmapped data", rd, 32'h0);
		$display("test irq done");
	endtask : t_irq
	// Prints the counts and the verdict, then ends the run.
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
	// Main sequence.
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		@(posedge ref_clk_i);
		t_fw();
		t_level();
		t_pulse();
		t_irq();
		wrap_up();
	end
	// Watchdog far beyond the expected run of about 520 cycles.
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		error_cnt++;
		wrap_up();
	end
endmodule : host_irq_line_control_tb_top
